// ===== design/rivec_consts.svh
// Constants for the reset and interrupt vectoring block.
// Behaviour
// RULE_01 - Twelve sources plus reset, each own vector.
// RULE_02 - Service needs own enable and global enable; vectors 8 to 12 have no own enable here, only the global one.
// RULE_03 - Lowest vector address wins among pending.
// RULE_04 - All resets go to vector zero.
// RULE_05 - External request 0 vector 1, request 1 vector 2.
// RULE_06 - Timer1 overflow, mask bit 7, vector 6.
// RULE_07 - Timer1 match A, mask bit 6, vector 4.
// RULE_08 - Timer1 match B, mask bit 5, vector 5.
// RULE_09 - Capture event, mask bit 3, vector 3.
// RULE_10 - Remaining sources take vectors seven to twelve.
// RULE_11 - Mask resets zero; bits 4,2,0 read zero.
// RULE_12 - Qualifying pin 0 edge sets flag bit 6.
// RULE_13 - Flag clears on vectoring or written one.
// RULE_14 - Level sensing holds request 0 flag cleared.
// RULE_15 - Start-up 256 or 16K watchdog cycles.
// RULE_16 - Hold core in reset until delay elapses.
// RULE_17 - Low reset pin keeps device in reset.
// RULE_18 - Set flag plus enables jumps to vector.
// RULE_19 - Taking clears global enable; return sets it.
// RULE_20 - Select at boundaries; flag clears when taken.
`ifndef RIVEC_CONSTS_SVH
`define RIVEC_CONSTS_SVH
`define RIVEC_ADDR_TIMER_MASK 6'h39
`define RIVEC_ADDR_GEN_MASK 6'h3b
`define RIVEC_ADDR_EXT_FLAG 6'h3a
`define RIVEC_ADDR_STATUS 6'h3f
`define RIVEC_ADDR_EXT_CTRL 6'h35
`define RIVEC_TIMER_MASK_RW 8'hea
`define RIVEC_TIMER_MASK_RST 8'h00
`define RIVEC_BIT_T1_OVF 7
`define RIVEC_BIT_T1_MA 6
`define RIVEC_BIT_T1_MB 5
`define RIVEC_BIT_T1_CAP 3
`define RIVEC_BIT_T0_OVF 1
`define RIVEC_BIT_EXT0 6
`define RIVEC_BIT_EXT1 7
`define RIVEC_BIT_GIE 7
`define RIVEC_NUM_SRC 12
`define RIVEC_START_FAST 16'h0100
`define RIVEC_START_SLOW 16'h4000
`endif

// ===== design/rivec_pkg.sv
// Types for the reset and interrupt vectoring block.
package rivec_pkg;
    typedef enum logic [1:0] {RIVEC_RESET, RIVEC_START, RIVEC_RUN} rivec_mode_t;
    typedef struct packed {
        logic [11:0] pend;
        logic [11:0] ack;
    } rivec_src_t;
    typedef struct packed {
        rivec_mode_t mode;
        logic [15:0] start_cnt;
        logic [2:0] wdo_sync;
        logic [2:0] pin_sync;
        logic ext0_prev;
        logic [7:0] timer_mask;
        logic [7:0] gen_mask;
        logic ext0_flag;
        logic gie;
        logic [1:0] ext0_sense;
        logic [7:0] rdata;
        logic core_reset;
        logic take;
        logic [3:0] vector;
        logic [11:0] ack;
    } rivec_state_t;
endpackage

// ===== design/rivec_top.sv
// Reset hold-off, interrupt gating, priority and vector selection.
`timescale 1ns/1ns
`default_nettype none
`include "rivec_consts.svh"
module rivec_top
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_POWER_ON_RST,
    input wire logic I_WATCHDOG_RST,
    input wire logic I_WDOG_OSC,
    input wire logic I_FAST_START_FUSE,
    input wire logic I_EXT_REQUEST_0,
    input wire logic I_EXT_REQ1_PEND,
    input wire logic I_T1_CAPTURE_FLAG,
    input wire logic I_T1_MATCH_A_FLAG,
    input wire logic I_T1_MATCH_B_FLAG,
    input wire logic I_T1_OVERFLOW_FLAG,
    input wire logic I_T0_OVERFLOW_FLAG,
    input wire logic I_SPI_DONE,
    input wire logic I_UART_RX_DONE,
    input wire logic I_UART_DATA_EMPTY,
    input wire logic I_UART_TX_DONE,
    input wire logic I_ANA_COMP,
    input wire logic I_INSTR_BOUNDARY,
    input wire logic I_RETURN_FROM_IRQ,
    input wire logic [5:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    output logic O_CORE_RESET,
    output logic O_IRQ_TAKE,
    output logic [3:0] O_IRQ_VECTOR,
    output logic [11:0] O_IRQ_ACK
);
    rivec_pkg::rivec_state_t st;
    rivec_pkg::rivec_state_t next_st;
    logic [11:0] req;
    logic [11:0] en;
    logic [11:0] live;
    logic wdo_rise;
    logic ext0_edge;
    logic [3:0] sel;
    logic any;
    logic [15:0] limit;

    always_comb
    begin
        wdo_rise = st.wdo_sync[1] && !st.wdo_sync[2];
        // The pin level counts only once the second and third stages agree.
        case (st.ext0_sense)
            2'b10: ext0_edge = st.ext0_prev && !st.pin_sync[1] && !st.pin_sync[2];
            2'b11: ext0_edge = !st.ext0_prev && st.pin_sync[1] && st.pin_sync[2];
            default: ext0_edge = 1'b0;
        endcase
        limit = I_FAST_START_FUSE ? `RIVEC_START_FAST : `RIVEC_START_SLOW; // RULE_15
        // Index i holds the source at vector i+1.
        req = {I_ANA_COMP, I_UART_TX_DONE, I_UART_DATA_EMPTY, I_UART_RX_DONE,
               I_SPI_DONE, I_T0_OVERFLOW_FLAG, I_T1_OVERFLOW_FLAG,
               I_T1_MATCH_B_FLAG, I_T1_MATCH_A_FLAG, I_T1_CAPTURE_FLAG,
               I_EXT_REQ1_PEND,
               (st.ext0_sense == 2'b00) ? 1'b0 : st.ext0_flag}; // RULE_01 RULE_10
        if (st.ext0_sense == 2'b00)
        begin
            req[0] = 1'b0;
        end
        en = {5'h00, st.timer_mask[`RIVEC_BIT_T0_OVF],
              st.timer_mask[`RIVEC_BIT_T1_OVF], st.timer_mask[`RIVEC_BIT_T1_MB],
              st.timer_mask[`RIVEC_BIT_T1_MA], st.timer_mask[`RIVEC_BIT_T1_CAP],
              st.gen_mask[`RIVEC_BIT_EXT1], st.gen_mask[`RIVEC_BIT_EXT0]}; // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
        en[11:7] = 5'h1f;
        live = (st.gie ? (req & en) : 12'h000); // RULE_02 RULE_18
        sel = 4'h0;
        any = 1'b0;
        for (int i = 11; i >= 0; i--)
        begin
            if (live[i])
            begin
                sel = 4'(i + 1); // RULE_03
                any = 1'b1;
            end
        end
    end

    always_comb
    begin
        next_st = st;
        next_st.wdo_sync = {st.wdo_sync[1:0], I_WDOG_OSC};
        next_st.pin_sync = {st.pin_sync[1:0], I_EXT_REQUEST_0};
        if (st.pin_sync[1] == st.pin_sync[2])
        begin
            next_st.ext0_prev = st.pin_sync[2];
        end
        next_st.take = 1'b0;
        next_st.ack = 12'h000;
        next_st.rdata = 8'h00;
        case (st.mode)
            rivec_pkg::RIVEC_RESET:
            begin
                next_st.mode = rivec_pkg::RIVEC_START;
                next_st.start_cnt = 16'h0000;
                next_st.core_reset = 1'b1;
            end
            rivec_pkg::RIVEC_START:
            begin
                next_st.core_reset = 1'b1;
                if (wdo_rise)
                begin
                    next_st.start_cnt = st.start_cnt + 16'h0001; // RULE_16
                end
                if (st.start_cnt >= limit)
                begin
                    next_st.mode = rivec_pkg::RIVEC_RUN;
                    next_st.core_reset = 1'b0;
                    next_st.vector = 4'h0; // RULE_04
                end
            end
            rivec_pkg::RIVEC_RUN:
            begin
                next_st.core_reset = 1'b0;
                if (I_RETURN_FROM_IRQ)
                begin
                    next_st.gie = 1'b1; // RULE_19
                end
                if (I_INSTR_BOUNDARY && any) // RULE_20
                begin
                    next_st.take = 1'b1;
                    next_st.vector = sel;
                    next_st.ack[sel - 4'h1] = 1'b1;
                    next_st.gie = 1'b0; // RULE_19
                end
            end
            default: next_st.mode = rivec_pkg::RIVEC_RESET;
        endcase
        if (I_WR)
        begin
            case (I_ADDR)
                `RIVEC_ADDR_TIMER_MASK: next_st.timer_mask = I_WDATA & `RIVEC_TIMER_MASK_RW; // RULE_11
                `RIVEC_ADDR_GEN_MASK: next_st.gen_mask = I_WDATA & 8'hc0;
                `RIVEC_ADDR_STATUS: next_st.gie = I_WDATA[`RIVEC_BIT_GIE];
                `RIVEC_ADDR_EXT_CTRL: next_st.ext0_sense = I_WDATA[1:0];
                default: next_st.gie = next_st.gie;
            endcase
        end
        if (I_WR && (I_ADDR == `RIVEC_ADDR_EXT_FLAG) && I_WDATA[`RIVEC_BIT_EXT0])
        begin
            next_st.ext0_flag = 1'b0; // RULE_13
        end
        if (next_st.take && (sel == 4'h1))
        begin
            next_st.ext0_flag = 1'b0; // RULE_13 RULE_20
        end
        if (ext0_edge)
        begin
            next_st.ext0_flag = 1'b1; // RULE_12
        end
        if (st.ext0_sense == 2'b00)
        begin
            next_st.ext0_flag = 1'b0; // RULE_14
        end
        if (I_RD)
        begin
            case (I_ADDR)
                `RIVEC_ADDR_TIMER_MASK: next_st.rdata = st.timer_mask; // RULE_11
                `RIVEC_ADDR_GEN_MASK: next_st.rdata = st.gen_mask;
                `RIVEC_ADDR_EXT_FLAG: next_st.rdata = {1'b0, st.ext0_flag, 6'h00};
                `RIVEC_ADDR_STATUS: next_st.rdata = {st.gie, 7'h00};
                `RIVEC_ADDR_EXT_CTRL: next_st.rdata = {6'h00, st.ext0_sense};
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // Any reset source restarts the hold-off; the pin is asynchronous.
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N) // RULE_17
        begin
            st <= '0;
            st.mode <= rivec_pkg::RIVEC_RESET;
            st.core_reset <= 1'b1;
            st.timer_mask <= `RIVEC_TIMER_MASK_RST;
        end
        else if (I_POWER_ON_RST || I_WATCHDOG_RST) // RULE_04
        begin
            st <= '0;
            st.mode <= rivec_pkg::RIVEC_RESET;
            st.core_reset <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign O_RDATA = st.rdata;
    assign O_CORE_RESET = st.core_reset;
    assign O_IRQ_TAKE = st.take;
    assign O_IRQ_VECTOR = st.vector;
    assign O_IRQ_ACK = st.ack;
endmodule
`default_nettype wire

// ===== verification/rivec_assertions.sv
// Checker of the vectoring block outputs.
`timescale 1ns/1ns
`default_nettype none
module rivec_chk
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_INSTR_BOUNDARY,
    input wire logic I_RD,
    input wire logic [5:0] I_ADDR,
    input wire logic [7:0] O_RDATA,
    input wire logic O_CORE_RESET,
    input wire logic O_IRQ_TAKE,
    input wire logic [3:0] O_IRQ_VECTOR,
    input wire logic [11:0] O_IRQ_ACK
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    take_after_bnd_a: assert property (O_IRQ_TAKE |-> $past(I_INSTR_BOUNDARY))
        else $error("take without boundary");
    single_take_a: assert property (O_IRQ_TAKE |=> !O_IRQ_TAKE)
        else $error("take repeated");
    ack_onehot_a: assert property (O_IRQ_TAKE |-> $onehot(O_IRQ_ACK))
        else $error("ack not one hot");
    ack_quiet_a: assert property (!O_IRQ_TAKE |-> O_IRQ_ACK == 12'h000)
        else $error("ack without take");
    ack_vector_a: assert property (O_IRQ_TAKE |-> O_IRQ_ACK[O_IRQ_VECTOR - 4'h1])
        else $error("ack and vector differ");
    hold_no_take_a: assert property (O_CORE_RESET |-> !O_IRQ_TAKE)
        else $error("take while core held");
    rst_vector_a: assert property ($fell(O_CORE_RESET) |-> O_IRQ_VECTOR == 4'h0)
        else $error("start not at vector zero");
    mask_resv_a: assert property ($past(I_RD) && $past(I_ADDR) == 6'h39 |->
        (O_RDATA & 8'h15) == 8'h00) else $error("reserved mask bit set");
    cover property (O_IRQ_TAKE && O_IRQ_VECTOR == 4'h1);
    cover property (O_IRQ_TAKE && O_IRQ_VECTOR == 4'hc);
    cover property ($fell(O_CORE_RESET));
endmodule
`default_nettype wire

// ===== verification/rivec_core.sv
// Core model that gives instruction boundaries and interrupt returns.
`timescale 1ns/1ns
`default_nettype none
module rivec_core
(
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic i_take,
    output logic o_bnd,
    output logic o_ret
);
    logic [4:0] sh = 5'h00;
    assign o_ret = sh[4];
    always @(posedge i_clk)
    begin
        o_bnd <= i_run & ~o_bnd;
        sh <= {sh[3:0], i_take};
    end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the vectoring block.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic I_CLK_SYS = 1'h0, I_RST_N = 1'h0, I_POWER_ON_RST = 1'h0, I_WATCHDOG_RST = 1'h0;
    logic I_WDOG_OSC = 1'h0, I_FAST_START_FUSE = 1'h1, I_EXT_REQUEST_0 = 1'h1, run = 1'h0;
    logic I_WR = 1'h0, I_RD = 1'h0, ie, I_INSTR_BOUNDARY, I_RETURN_FROM_IRQ, O_CORE_RESET;
    logic O_IRQ_TAKE;
    logic [5:0] I_ADDR = 6'h00;
    logic [7:0] I_WDATA = 8'h00, O_RDATA, tm, gm;
    logic [10:0] src = 11'h000;
    logic [3:0] O_IRQ_VECTOR, ev;
    logic [11:0] O_IRQ_ACK, ak;
    integer seed = 3822, err_total = 0, total_checks = 0, cyc = 0, rises = 0, n;
    always #2 I_CLK_SYS = ~I_CLK_SYS;
    always #7 I_WDOG_OSC = ~I_WDOG_OSC;
    always @(posedge I_WDOG_OSC) rises = rises + 1;
    rivec_top rivec_top_inst (.I_CLK_SYS, .I_RST_N, .I_POWER_ON_RST, .I_WATCHDOG_RST,
        .I_WDOG_OSC, .I_FAST_START_FUSE, .I_EXT_REQUEST_0, .I_EXT_REQ1_PEND(src[0]),
        .I_T1_CAPTURE_FLAG(src[1]), .I_T1_MATCH_A_FLAG(src[2]), .I_T1_MATCH_B_FLAG(src[3]),
        .I_T1_OVERFLOW_FLAG(src[4]), .I_T0_OVERFLOW_FLAG(src[5]), .I_SPI_DONE(src[6]),
        .I_UART_RX_DONE(src[7]), .I_UART_DATA_EMPTY(src[8]), .I_UART_TX_DONE(src[9]),
        .I_ANA_COMP(src[10]), .I_INSTR_BOUNDARY, .I_RETURN_FROM_IRQ, .I_ADDR, .I_WDATA,
        .I_WR, .I_RD, .O_RDATA, .O_CORE_RESET, .O_IRQ_TAKE, .O_IRQ_VECTOR, .O_IRQ_ACK);
    rivec_core rivec_core_inst (.i_clk(I_CLK_SYS), .i_run(run & ~O_CORE_RESET),
        .i_take(O_IRQ_TAKE), .o_bnd(I_INSTR_BOUNDARY), .o_ret(I_RETURN_FROM_IRQ));
    task automatic results(input logic to);
        err_total = err_total + to;
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge I_CLK_SYS)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
            results(1'h1);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge I_CLK_SYS);
        I_ADDR <= a;
        I_WDATA <= d;
        {I_WR, I_RD} <= {w, !w};
        @(posedge I_CLK_SYS);
        {I_WR, I_RD} <= 2'h0;
        @(negedge I_CLK_SYS);
        if (!w) chk(O_RDATA, d);
    endtask
    task automatic waitt();
        n = 0;
        while (O_IRQ_TAKE !== 1'h1 && n++ < 30)
            @(negedge I_CLK_SYS);
    endtask
    task automatic pin();
        @(posedge I_CLK_SYS);
        I_EXT_REQUEST_0 <= 1'h0;
        repeat (5) @(posedge I_CLK_SYS);
        I_EXT_REQUEST_0 <= 1'h1;
        repeat (6) @(posedge I_CLK_SYS);
    endtask
    task automatic boot(input logic [1:0] k);
        @(posedge I_CLK_SYS);
        {I_WATCHDOG_RST, I_POWER_ON_RST, I_RST_N} <= {k, k != 2'h0};
        repeat (20) @(posedge I_CLK_SYS);
        chk(O_CORE_RESET, 1'h1);
        {I_WATCHDOG_RST, I_POWER_ON_RST, I_RST_N} <= 3'h1;
        rises = 0;
        n = 0;
        while (O_CORE_RESET !== 1'h0 && n++ < 2000)
            @(negedge I_CLK_SYS);
        chk(rises > 255 && rises < 259, 1'h1);
        chk(O_IRQ_VECTOR, 4'h0);
    endtask
    function automatic logic [3:0] expv(input logic [10:0] p, input logic [7:0] t, g);
        logic [10:0] en;
        en = p & {5'h1f, t[1], t[7], t[5], t[6], t[3], g[7]} & {11{ie}};
        expv = 4'h0;
        for (int i = 10; i >= 0; i--)
            if (en[i]) expv = 4'(i + 2);
    endfunction
    initial
    begin
        boot(2'h0);
        bus(1'h0, 6'h39, 8'h00);
        bus(1'h1, 6'h39, 8'hff);
        bus(1'h0, 6'h39, 8'hea);
        run <= 1'h1;
        repeat (40)
        begin
            {ie, gm, tm} = 17'($random(seed));
            bus(1'h1, 6'h39, tm);
            bus(1'h1, 6'h3b, gm);
            bus(1'h1, 6'h3f, {ie, 7'h00});
            @(posedge I_CLK_SYS);
            src <= 11'($random(seed));
            do
            begin
                @(negedge I_CLK_SYS);
                ev = expv(src, tm, gm);
                waitt();
                chk(O_IRQ_TAKE === 1'h1 ? O_IRQ_VECTOR : 4'h0, ev);
                ak = O_IRQ_ACK;
                @(posedge I_CLK_SYS);
                src <= src & ~ak[11:1];
            end while (ev != 4'h0);
            src <= 11'h000;
        end
        bus(1'h1, 6'h3f, 8'h00);
        bus(1'h1, 6'h3b, 8'h40);
        bus(1'h1, 6'h35, 8'h03);
        pin();
        bus(1'h0, 6'h3a, 8'h40);
        bus(1'h1, 6'h3a, 8'h40);
        bus(1'h0, 6'h3a, 8'h00);
        pin();
        bus(1'h1, 6'h3f, 8'h80);
        waitt();
        chk(O_IRQ_VECTOR, 4'h1);
        bus(1'h0, 6'h3f, 8'h00);
        bus(1'h0, 6'h3a, 8'h00);
        waitt();
        bus(1'h0, 6'h3f, 8'h80);
        bus(1'h1, 6'h3f, 8'h00);
        pin();
        bus(1'h1, 6'h35, 8'h00);
        bus(1'h0, 6'h3a, 8'h00);
        boot(2'h1);
        boot(2'h2);
        results(1'h0);
    end
endmodule
bind rivec_top rivec_chk rivec_chk_inst (.I_CLK_SYS, .I_RST_N, .I_INSTR_BOUNDARY, .I_RD,
    .I_ADDR, .O_RDATA, .O_CORE_RESET, .O_IRQ_TAKE, .O_IRQ_VECTOR, .O_IRQ_ACK);
`default_nettype wire
